//--- design/adc_cal_mux_gain_regs.sv
// Module: calibration, current source and input/gain register bank with Avalon-MM slave
// Notes on behaviour
// - Full-scale word is three byte registers, low byte first, reset 400000h.
// - Full-scale word is unsigned straight binary.
// - Data is multiplied by full-scale word over 400000h; reset word is unity.
// - Scaling happens only after offset correction.
// - The signed 24-bit offset word is subtracted before scaling.
// - Upper routing nibble: 1000 pin A, 1001 pin B, else open; reset 1111.
// - Lower routing nibble routes the first source the same way.
// - Upper magnitude nibble: 0000 off, 0001-1011 rising levels, top codes off.
// - Lower magnitude nibble sets the first source the same way; reset off.
// - Reserved byte at 0Fh resets to 00h, reads zero; software writes 00h.
// - Mode byte at 10h resets 50h; bit 7 reads zero; select 6:4, gain 3:0.
// - Select codes 000-011 choose the differential and common-referred pairs.
// - Select 100 supply/36, 101 mid-supply short, 110 temperature, 111 reserved.
// - Gain codes 0000-1011 give 0.125 to 128; 1100-1111 reserved.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
module adc_cal_mux_gain_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic conv_valid,
  input wire logic [23:0] conv_data,
  output logic cal_valid,
  output logic [23:0] cal_data,
  output cal_regs_pkg::analog_ctl_t analog_ctl
);

  // ********************************
  // Helpers
  // ********************************

  // Routing decode shared by both current sources
  function automatic cal_regs_pkg::route_t decode_route(input logic [3:0] code);
    cal_regs_pkg::route_t r;
    r.pin_a = (code == cal_regs_pkg::ROUTE_PIN_A);
    r.pin_b = (code == cal_regs_pkg::ROUTE_PIN_B);
    return r;
  endfunction

  // Magnitude decode: codes above the top level are forced to off
  function automatic logic [3:0] decode_level(input logic [3:0] code);
    decode_level = (code > cal_regs_pkg::LEVEL_TOP_CODE) ? 4'h0 : code;
  endfunction

  // ********************************
  // Register storage
  // ********************************
  logic [7:0] offset_low_reg, offset_low_next;
  logic [7:0] offset_mid_reg, offset_mid_next;
  logic [7:0] offset_high_reg, offset_high_next;
  logic [7:0] fs_low_reg, fs_low_next;
  logic [7:0] fs_mid_reg, fs_mid_next;
  logic [7:0] fs_high_reg, fs_high_next;
  logic [7:0] routing_reg, routing_next;
  logic [7:0] magnitude_reg, magnitude_next;
  logic [7:0] input_gain_reg, input_gain_next;
  logic [31:0] rdata_next;
  logic [1:0] resp_next;
  logic wait_next;
  logic busy_reg, busy_next;
  logic wr_take;
  logic mapped;
  logic [23:0] offset_word;
  logic [23:0] fullscale_word;
  cal_regs_pkg::analog_ctl_t ctl_next;

  // Write is taken on the single cycle waitrequest is low
  assign wr_take = avs_write && busy_reg;
  assign offset_word = {offset_high_reg, offset_mid_reg, offset_low_reg};
  assign fullscale_word = {fs_high_reg, fs_mid_reg, fs_low_reg};

  // Address decode; anything outside the map answers with a slave error
  always_comb begin
    case (avs_address)
      cal_regs_pkg::OFS_OFFSET_LOW, cal_regs_pkg::OFS_OFFSET_MID, cal_regs_pkg::OFS_OFFSET_HIGH,
      cal_regs_pkg::OFS_FULLSCALE_LOW, cal_regs_pkg::OFS_FULLSCALE_MID, cal_regs_pkg::OFS_FULLSCALE_HIGH,
      cal_regs_pkg::OFS_ROUTING, cal_regs_pkg::OFS_MAGNITUDE, cal_regs_pkg::OFS_RESERVED,
      cal_regs_pkg::OFS_INPUT_GAIN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Next register values from a bus write; only byte lane 0 carries data
  always_comb begin
    offset_low_next = offset_low_reg;
    offset_mid_next = offset_mid_reg;
    offset_high_next = offset_high_reg;
    fs_low_next = fs_low_reg;
    fs_mid_next = fs_mid_reg;
    fs_high_next = fs_high_reg;
    routing_next = routing_reg;
    magnitude_next = magnitude_reg;
    input_gain_next = input_gain_reg;
    if (wr_take && avs_byteenable[0]) begin
      case (avs_address)
        cal_regs_pkg::OFS_OFFSET_LOW: offset_low_next = avs_writedata[7:0];
        cal_regs_pkg::OFS_OFFSET_MID: offset_mid_next = avs_writedata[7:0];
        cal_regs_pkg::OFS_OFFSET_HIGH: offset_high_next = avs_writedata[7:0];
        cal_regs_pkg::OFS_FULLSCALE_LOW: fs_low_next = avs_writedata[7:0];
        cal_regs_pkg::OFS_FULLSCALE_MID: fs_mid_next = avs_writedata[7:0];
        cal_regs_pkg::OFS_FULLSCALE_HIGH: fs_high_next = avs_writedata[7:0];
        cal_regs_pkg::OFS_ROUTING: routing_next = avs_writedata[7:0];
        cal_regs_pkg::OFS_MAGNITUDE: magnitude_next = avs_writedata[7:0];
        // Bit 7 is not stored, reserved codes are kept as written
        cal_regs_pkg::OFS_INPUT_GAIN: input_gain_next = avs_writedata[7:0] & cal_regs_pkg::INPUT_GAIN_MASK;
        default: input_gain_next = input_gain_reg; // Reserved byte keeps no state
      endcase
    end
  end

  // Bus answer: one wait cycle, then waitrequest low for one cycle with data
  always_comb begin
    busy_next = 1'b0;
    wait_next = 1'b1;
    rdata_next = avs_readdata;
    resp_next = avs_response;
    if ((avs_read || avs_write) && !busy_reg) begin
      busy_next = 1'b1;
      wait_next = 1'b0;
      resp_next = mapped ? 2'b00 : 2'b10;
      rdata_next = 32'h00000000;
      case (avs_address)
        cal_regs_pkg::OFS_OFFSET_LOW: rdata_next[7:0] = offset_low_reg;
        cal_regs_pkg::OFS_OFFSET_MID: rdata_next[7:0] = offset_mid_reg;
        cal_regs_pkg::OFS_OFFSET_HIGH: rdata_next[7:0] = offset_high_reg;
        cal_regs_pkg::OFS_FULLSCALE_LOW: rdata_next[7:0] = fs_low_reg;
        cal_regs_pkg::OFS_FULLSCALE_MID: rdata_next[7:0] = fs_mid_reg;
        cal_regs_pkg::OFS_FULLSCALE_HIGH: rdata_next[7:0] = fs_high_reg;
        cal_regs_pkg::OFS_ROUTING: rdata_next[7:0] = routing_reg;
        cal_regs_pkg::OFS_MAGNITUDE: rdata_next[7:0] = magnitude_reg;
        cal_regs_pkg::OFS_RESERVED: rdata_next[7:0] = cal_regs_pkg::RST_RESERVED;
        cal_regs_pkg::OFS_INPUT_GAIN: rdata_next[7:0] = input_gain_reg;
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // Analog control decode, registered so every output comes from a flop
  always_comb begin
    ctl_next.second_route = decode_route(routing_reg[7:cal_regs_pkg::SRC_HI_LSB]);
    ctl_next.first_route = decode_route(routing_reg[3:0]);
    ctl_next.second_level = decode_level(magnitude_reg[7:cal_regs_pkg::SRC_HI_LSB]);
    ctl_next.first_level = decode_level(magnitude_reg[3:0]);
    ctl_next.input_select = input_gain_reg[6:cal_regs_pkg::SEL_LSB];
    ctl_next.gain_code = input_gain_reg[3:0];
    ctl_next.gain_valid = (input_gain_reg[3:0] <= cal_regs_pkg::GAIN_TOP_CODE);
  end

  // ********************************
  // State registers
  // ********************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      offset_low_reg <= cal_regs_pkg::RST_OFFSET_BYTE;
      offset_mid_reg <= cal_regs_pkg::RST_OFFSET_BYTE;
      offset_high_reg <= cal_regs_pkg::RST_OFFSET_BYTE;
      fs_low_reg <= cal_regs_pkg::RST_FULLSCALE_LOW;
      fs_mid_reg <= cal_regs_pkg::RST_FULLSCALE_MID;
      fs_high_reg <= cal_regs_pkg::RST_FULLSCALE_HIGH;
      routing_reg <= cal_regs_pkg::RST_ROUTING;
      magnitude_reg <= cal_regs_pkg::RST_MAGNITUDE;
      input_gain_reg <= cal_regs_pkg::RST_INPUT_GAIN;
      busy_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      avs_response <= 2'b00;
      analog_ctl <= '0;
    end else begin
      offset_low_reg <= offset_low_next;
      offset_mid_reg <= offset_mid_next;
      offset_high_reg <= offset_high_next;
      fs_low_reg <= fs_low_next;
      fs_mid_reg <= fs_mid_next;
      fs_high_reg <= fs_high_next;
      routing_reg <= routing_next;
      magnitude_reg <= magnitude_next;
      input_gain_reg <= input_gain_next;
      busy_reg <= busy_next;
      avs_waitrequest <= wait_next;
      avs_readdata <= rdata_next;
      avs_response <= resp_next;
      analog_ctl <= ctl_next;
    end
  end

  // ********************************
  // Data path
  // ********************************

  // Offset first, full-scale second; latency two cycles
  cal_scaler u_scaler (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(conv_valid),
    .in_data(conv_data),
    .offset_word(offset_word),
    .fullscale_word(fullscale_word),
    .out_valid(cal_valid),
    .out_data(cal_data)
  );

  // ********************************
  // Assertions
  // ********************************
  a_fs_reset_word: assert property (@(posedge sys_clk) $fell(rst) |-> fullscale_word == cal_regs_pkg::FULLSCALE_UNITY)
    else $error("full-scale word not 400000h after reset");
  a_bit7_zero: assert property (@(posedge sys_clk) disable iff (rst) !input_gain_reg[7])
    else $error("mode bit 7 stored");
  a_rsvd_reads_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_read && !busy_reg && avs_address == cal_regs_pkg::OFS_RESERVED) |=> avs_readdata == 32'h0)
    else $error("reserved byte read non-zero");
  a_route_pin_a: assert property (@(posedge sys_clk) disable iff (rst)
    routing_reg[3:0] == 4'h8 |=> analog_ctl.first_route == 2'b01)
    else $error("first route pin A wrong");
  a_route_second: assert property (@(posedge sys_clk) disable iff (rst)
    routing_reg[7:4] == 4'h9 |=> analog_ctl.second_route == 2'b10)
    else $error("second route pin B wrong");
  a_level_top_off: assert property (@(posedge sys_clk) disable iff (rst)
    magnitude_reg[3:0] > 4'hb |=> analog_ctl.first_level == 4'h0)
    else $error("first level top code not off");
  a_level_second: assert property (@(posedge sys_clk) disable iff (rst)
    magnitude_reg[7:4] <= 4'hb |=> analog_ctl.second_level == $past(magnitude_reg[7:4]))
    else $error("second level mismatch");
  a_rsvd_code_kept: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_take && avs_byteenable[0] && avs_address == cal_regs_pkg::OFS_INPUT_GAIN)
    |=> input_gain_reg == ($past(avs_writedata[7:0]) & 8'h7f))
    else $error("mode write not stored");
  a_unity_passes: assert property (@(posedge sys_clk) disable iff (rst)
    (conv_valid && fullscale_word == 24'h400000 && offset_word == 24'h0) ##1
    (fullscale_word == 24'h400000 && offset_word == 24'h0) |=> cal_valid && cal_data == $past(conv_data, 2))
    else $error("unity scaling changed data");
  a_gain_valid: assert property (@(posedge sys_clk) disable iff (rst)
    !rst |=> analog_ctl.gain_valid == ($past(input_gain_reg[3:0]) < 4'hc))
    else $error("gain valid flag wrong");
  a_answer_one: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |-> ##[0:1] !avs_waitrequest)
    else $error("bus answer late");
  // The answer stands one cycle; unmapped addresses are refused with no data
  a_answer_stands: assert property (@(posedge sys_clk) disable iff (rst) !avs_waitrequest |=> avs_waitrequest)
    else $error("answer held over one cycle");
  a_unmapped_error: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_read || avs_write) && !busy_reg && !mapped |=> avs_response == 2'b10 && avs_readdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_okay: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_read || avs_write) && !busy_reg && mapped |=> avs_response == 2'b00)
    else $error("mapped access not okay");
  a_mode_read: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_read && !busy_reg && avs_address == cal_regs_pkg::OFS_INPUT_GAIN)
    |=> avs_readdata[7:0] == $past(input_gain_reg))
    else $error("mode read data wrong");

  // ********************************
  // Register write checks
  // ********************************

  // Each byte lands on its own write; a disabled lane or the reserved byte stores nothing
  a_fs_low_write: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_take && avs_byteenable[0] && avs_address == cal_regs_pkg::OFS_FULLSCALE_LOW)
    |=> fs_low_reg == $past(avs_writedata[7:0]))
    else $error("full-scale low not stored");
  a_fs_mid_write: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_take && avs_byteenable[0] && avs_address == cal_regs_pkg::OFS_FULLSCALE_MID)
    |=> fs_mid_reg == $past(avs_writedata[7:0]))
    else $error("full-scale mid not stored");
  a_fs_high_write: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_take && avs_byteenable[0] && avs_address == cal_regs_pkg::OFS_FULLSCALE_HIGH)
    |=> fs_high_reg == $past(avs_writedata[7:0]))
    else $error("full-scale high not stored");
  a_route_write: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_take && avs_byteenable[0] && avs_address == cal_regs_pkg::OFS_ROUTING)
    |=> routing_reg == $past(avs_writedata[7:0]))
    else $error("routing not stored");
  a_mag_write: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_take && avs_byteenable[0] && avs_address == cal_regs_pkg::OFS_MAGNITUDE)
    |=> magnitude_reg == $past(avs_writedata[7:0]))
    else $error("magnitude not stored");
  a_offset_write: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_take && avs_byteenable[0] && avs_address == cal_regs_pkg::OFS_OFFSET_HIGH)
    |=> offset_high_reg == $past(avs_writedata[7:0]))
    else $error("offset high not stored");
  a_lane_masked: assert property (@(posedge sys_clk) disable iff (rst)
    wr_take && !avs_byteenable[0] |=> magnitude_reg == $past(magnitude_reg) && fullscale_word == $past(fullscale_word))
    else $error("masked write landed");
  a_rsvd_no_store: assert property (@(posedge sys_clk) disable iff (rst)
    wr_take && avs_address == cal_regs_pkg::OFS_RESERVED |=> $stable({routing_reg, magnitude_reg, input_gain_reg}))
    else $error("reserved write changed state");

  // ********************************
  // Decoded control checks
  // ********************************

  // Controls follow their registers one cycle later; the cycle leaving reset is skipped
  a_route_first_b: assert property (@(posedge sys_clk) disable iff (rst)
    !rst && routing_reg[3:0] == 4'h9 |=> analog_ctl.first_route == 2'b10)
    else $error("first route pin B wrong");
  a_route_first_open: assert property (@(posedge sys_clk) disable iff (rst)
    !rst && routing_reg[3:0] != 4'h8 && routing_reg[3:0] != 4'h9 |=> analog_ctl.first_route == 2'b00)
    else $error("first route not open");
  a_route_second_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rst && routing_reg[7:4] == 4'h8 |=> analog_ctl.second_route == 2'b01)
    else $error("second route pin A wrong");
  a_route_second_open: assert property (@(posedge sys_clk) disable iff (rst)
    !rst && routing_reg[7:4] != 4'h8 && routing_reg[7:4] != 4'h9 |=> analog_ctl.second_route == 2'b00)
    else $error("second route not open");
  a_level_first: assert property (@(posedge sys_clk) disable iff (rst)
    !rst && magnitude_reg[3:0] <= 4'hb |=> analog_ctl.first_level == $past(magnitude_reg[3:0]))
    else $error("first level mismatch");
  a_level_second_off: assert property (@(posedge sys_clk) disable iff (rst)
    !rst && magnitude_reg[7:4] > 4'hb |=> analog_ctl.second_level == 4'h0)
    else $error("second level top code not off");
  a_select_follow: assert property (@(posedge sys_clk) disable iff (rst)
    !rst |=> analog_ctl.input_select == $past(input_gain_reg[6:4]))
    else $error("input select mismatch");
  a_gain_follow: assert property (@(posedge sys_clk) disable iff (rst)
    !rst |=> analog_ctl.gain_code == $past(input_gain_reg[3:0]))
    else $error("gain code mismatch");
  a_ctl_reset: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(rst) |=> analog_ctl.input_select == 3'h5 && analog_ctl.gain_code == 4'h0)
    else $error("controls not at reset decode");

  // ********************************
  // Data path checks
  // ********************************

  // Every sample gives one result two edges later, and the result holds in between
  a_result_latency: assert property (@(posedge sys_clk) disable iff (rst) conv_valid |-> ##2 cal_valid)
    else $error("result latency wrong");
  a_result_holds: assert property (@(posedge sys_clk) disable iff (rst) !cal_valid |-> $stable(cal_data))
    else $error("result changed without valid");
  a_offset_reset: assert property (@(posedge sys_clk) $fell(rst) |-> offset_word == 24'h000000)
    else $error("offset word not zero after reset");

  c_fs_write: cover property (@(posedge sys_clk) wr_take && avs_address == cal_regs_pkg::OFS_FULLSCALE_HIGH);
  c_mode_read: cover property (@(posedge sys_clk) avs_read && !avs_waitrequest && avs_address == cal_regs_pkg::OFS_INPUT_GAIN);
  c_unmapped: cover property (@(posedge sys_clk) !avs_waitrequest && avs_response == 2'b10);
  c_cal_out: cover property (@(posedge sys_clk) cal_valid);
  // A reserved gain code reaching the decoded controls
  c_gain_rsvd: cover property (@(posedge sys_clk) !rst && !analog_ctl.gain_valid);

endmodule

//--- include/cal_regs_pkg.sv
// Package: register map, field layout, reset values and carriers for the calibration bank
package cal_regs_pkg;

  // ********************************
  // Register offsets (byte addresses index, word address = index)
  // ********************************
  localparam logic [4:0] OFS_OFFSET_LOW = 5'h07;
  localparam logic [4:0] OFS_OFFSET_MID = 5'h08;
  localparam logic [4:0] OFS_OFFSET_HIGH = 5'h09;
  localparam logic [4:0] OFS_FULLSCALE_LOW = 5'h0a;
  localparam logic [4:0] OFS_FULLSCALE_MID = 5'h0b;
  localparam logic [4:0] OFS_FULLSCALE_HIGH = 5'h0c;
  localparam logic [4:0] OFS_ROUTING = 5'h0d;
  localparam logic [4:0] OFS_MAGNITUDE = 5'h0e;
  localparam logic [4:0] OFS_RESERVED = 5'h0f;
  localparam logic [4:0] OFS_INPUT_GAIN = 5'h10;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [7:0] RST_OFFSET_BYTE = 8'h00;
  localparam logic [7:0] RST_FULLSCALE_LOW = 8'h00;
  localparam logic [7:0] RST_FULLSCALE_MID = 8'h00;
  localparam logic [7:0] RST_FULLSCALE_HIGH = 8'h40;
  localparam logic [7:0] RST_ROUTING = 8'hff;
  localparam logic [7:0] RST_MAGNITUDE = 8'h00;
  localparam logic [7:0] RST_RESERVED = 8'h00;
  localparam logic [7:0] RST_INPUT_GAIN = 8'h50;

  // ********************************
  // Field layout and codes
  // ********************************
  localparam int SRC_HI_LSB = 4;
  localparam int SEL_LSB = 4;
  localparam logic [7:0] INPUT_GAIN_MASK = 8'h7f;
  localparam logic [3:0] ROUTE_PIN_A = 4'h8;
  localparam logic [3:0] ROUTE_PIN_B = 4'h9;
  localparam logic [3:0] LEVEL_TOP_CODE = 4'hb;
  localparam logic [23:0] FULLSCALE_UNITY = 24'h400000;
  localparam int UNITY_SHIFT = 22;
  localparam logic [3:0] GAIN_TOP_CODE = 4'hb;
  localparam logic [2:0] SEL_RESERVED = 3'h7;

  // Routing of one current source onto the two output pins
  typedef struct packed {
    logic pin_b;
    logic pin_a;
  } route_t;

  // Decoded analog controls
  typedef struct packed {
    route_t first_route;
    route_t second_route;
    logic [3:0] first_level;
    logic [3:0] second_level;
    logic [2:0] input_select;
    logic [3:0] gain_code;
    logic gain_valid;
  } analog_ctl_t;

endpackage

//--- design/cal_scaler.sv
// Module: offset removal followed by full-scale scaling of conversion data
`timescale 1ns/1ps
module cal_scaler (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [23:0] in_data,
  input wire logic [23:0] offset_word,
  input wire logic [23:0] fullscale_word,
  output logic out_valid,
  output logic [23:0] out_data
);

  // ********************************
  // Two stage pipeline
  // ********************************
  logic [24:0] diff_reg, diff_next;
  logic stage_reg, stage_next;
  logic [23:0] out_data_next;
  logic out_valid_next;
  logic signed [49:0] prod;
  logic signed [49:0] scaled;

  // Stage one subtracts the offset; 25 bits hold the difference without wrap
  always_comb begin
    stage_next = in_valid;
    diff_next = diff_reg;
    if (in_valid) begin
      diff_next = 25'($signed(in_data)) - 25'($signed(offset_word));
    end
  end

  // Stage two scales by the unsigned word over 400000h and saturates to 24 bits
  always_comb begin
    prod = $signed(diff_reg) * $signed({1'b0, fullscale_word});
    scaled = prod >>> cal_regs_pkg::UNITY_SHIFT;
    out_valid_next = stage_reg;
    out_data_next = out_data;
    if (stage_reg) begin
      if (scaled > 50'sh7fffff) begin
        out_data_next = 24'h7fffff;
      end else if (scaled < -50'sh800000) begin
        out_data_next = 24'h800000;
      end else begin
        out_data_next = scaled[23:0];
      end
    end
  end

  // Pipeline registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      diff_reg <= 25'h0000000;
      stage_reg <= 1'b0;
      out_valid <= 1'b0;
      out_data <= 24'h000000;
    end else begin
      diff_reg <= diff_next;
      stage_reg <= stage_next;
      out_valid <= out_valid_next;
      out_data <= out_data_next;
    end
  end

endmodule

//--- verif/testbench.sv
// Self-checking bench for the calibration, current source and input/gain register bank
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin err_total++; \
  $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, msg, got, exp); end end
module testbench;
  logic sys_clk;
  logic rst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic conv_valid;
  logic [23:0] conv_data;
  logic cal_valid;
  logic [23:0] cal_data;
  cal_regs_pkg::analog_ctl_t analog_ctl;
  int err_total;
  int checked;
  int cycles;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [7:0] v;
  logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'h40, 8'hff, 8'h00, 8'h00, 8'h50};
  logic [7:0] route_tab [4] = '{8'h98, 8'h89, 8'h7a, 8'h0f};

  adc_cal_mux_gain_regs i_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .conv_valid(conv_valid), .conv_data(conv_data), .cal_valid(cal_valid), .cal_data(cal_data),
    .analog_ctl(analog_ctl));

  // ****************************************
  // Clock, timeout and closing report
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Bus, sample and expectation helpers
  // ****************************************
  // One Avalon access; request held until waitrequest is sampled low; a dead slave trips the bench timeout
  task automatic access(input logic wr, input logic [4:0] addr, input logic [7:0] data, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= addr;
    avs_writedata <= {24'h0, data};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rsp = avs_response;
    `CHK(n, 2, "bus answer wait")
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Low byte goes to the lowest address
  task automatic set_word(input logic [4:0] base, input logic [23:0] w);
    access(1'b1, base, w[7:0], 4'h1);
    access(1'b1, base + 5'h1, w[15:8], 4'h1);
    access(1'b1, base + 5'h2, w[23:16], 4'h1);
  endtask

  // Decoded controls follow the registers one cycle late; two edges leaves margin
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // One sample in, result expected exactly two edges later
  task automatic conv(input logic [23:0] x, input logic [23:0] exp);
    int n;
    n = 0;
    @(posedge sys_clk);
    conv_valid <= 1'b1;
    conv_data <= x;
    @(posedge sys_clk);
    conv_valid <= 1'b0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (cal_valid !== 1'b1 && n < 10);
    `CHK(n, 1, "result latency")
    `CHK(cal_data, exp, "scaled result")
  endtask

  function automatic cal_regs_pkg::route_t rexp(input logic [3:0] c);
    rexp.pin_a = (c == 4'h8);
    rexp.pin_b = (c == 4'h9);
  endfunction

  function automatic logic [3:0] lvl(input logic [3:0] c);
    lvl = (c > 4'hb) ? 4'h0 : c;
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    conv_valid = 1'b0;
    conv_data = 24'h0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK(analog_ctl.first_route, 2'b00, "reset first route")
    `CHK(analog_ctl.second_route, 2'b00, "reset second route")
    `CHK(analog_ctl.input_select, 3'h5, "reset select")
    `CHK(analog_ctl.gain_code, 4'h0, "reset gain")
    `CHK(analog_ctl.gain_valid, 1'b1, "reset gain valid")
    `CHK(analog_ctl.first_level, 4'h0, "reset first level")
    // Reset values and plain OKAY response from the full-scale low byte up to the mode byte
    for (int i = 0; i < 7; i++) begin
      access(1'b0, 5'h0a + i[4:0], 8'h00, 4'h1);
      `CHK(rd, {24'h0, rst_tab[i]}, "reset value")
      `CHK(rsp, 2'b00, "response")
    end
    for (int i = 0; i < 4; i++) begin
      access(1'b1, 5'h0d, route_tab[i], 4'h1);
      settle();
      `CHK(analog_ctl.second_route, rexp(route_tab[i][7:4]), "second route")
      `CHK(analog_ctl.first_route, rexp(route_tab[i][3:0]), "first route")
    end
    // Opposite nibbles so both sources see every code, the off codes included
    for (int i = 0; i < 16; i++) begin
      v = {i[3:0], ~i[3:0]};
      access(1'b1, 5'h0e, v, 4'h1);
      settle();
      `CHK(analog_ctl.second_level, lvl(v[7:4]), "second level")
      `CHK(analog_ctl.first_level, lvl(v[3:0]), "first level")
      access(1'b0, 5'h0e, 8'h00, 4'h1);
      `CHK(rd, {24'h0, v}, "level readback")
    end
    // Byte lane disabled: the write must not land
    access(1'b1, 5'h0e, 8'h55, 4'h0);
    access(1'b0, 5'h0e, 8'h00, 4'h1);
    `CHK(rd, 32'h000000f0, "masked write")
    access(1'b1, 5'h0f, 8'h00, 4'h1);
    access(1'b0, 5'h0f, 8'h00, 4'h1);
    `CHK(rd, 32'h0, "reserved byte")
    access(1'b0, 5'h1f, 8'h00, 4'h1);
    `CHK(rsp, 2'b10, "unmapped response")
    `CHK(rd, 32'h0, "unmapped data")
    access(1'b1, 5'h10, 8'hff, 4'h1);
    access(1'b0, 5'h10, 8'h00, 4'h1);
    `CHK(rd, 32'h0000007f, "mode top bit")
    // Every select code and every gain code, reserved ones too
    for (int i = 0; i < 16; i++) begin
      v = {1'b0, i[2:0], i[3:0]};
      access(1'b1, 5'h10, v, 4'h1);
      settle();
      `CHK(analog_ctl.input_select, i[2:0], "select")
      `CHK(analog_ctl.gain_code, i[3:0], "gain")
      `CHK(analog_ctl.gain_valid, (i < 12), "gain valid")
      access(1'b0, 5'h10, 8'h00, 4'h1);
      `CHK(rd, {24'h0, v}, "mode readback")
    end
    // Data path: the order of subtract and scale changes every result after the first
    conv(24'h123456, 24'h123456);
    set_word(5'h07, 24'h000010);
    set_word(5'h0a, 24'h200000);
    conv(24'h000100, 24'h000078);
    conv(24'hffff00, 24'hffff78);
    set_word(5'h0a, 24'h800000);
    conv(24'h000100, 24'h0001e0);
    set_word(5'h0a, 24'h010000);
    conv(24'h004010, 24'h000100);
    wrap_up();
  end
endmodule
